//--- acc_clock_regs.v
// clock configuration registers, page pointer stepping and clock error detectors
// How it works
// - wrap enabled, nonzero book: next page address 8
// - wrap disabled: back to address 0, same page
// - hold bit-clock ratio setting in bits 7-4
// - decode sample-rate select; host writes listed codes
// - flag PLL overrate; bit 6 ignores it
// - flag bit-clock range error; bit 5 ignores it
// - bit 4 ignores rate error, status still reports
// - flag ratio outside 32..512; bit 3 ignores
// - flag missing bit clock, also as range error; bit 2 ignores the miss flag only
// - serial output picks post or pre DSP data
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.vh"
module acc_clock_regs (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        clkEn,
	input  wire        ptrLoad,
	input  wire [7:0]  ptrBook,
	input  wire [7:0]  ptrPage,
	input  wire [6:0]  ptrAddr,
	input  wire        accStrobe,
	input  wire        accWrite,
	input  wire [7:0]  accWrData,
	output reg  [7:0]  accRdData_q,
	output reg         accRdValid_q,
	output reg  [7:0]  curBook_q,
	output reg  [7:0]  curPage_q,
	output reg  [6:0]  curAddr_q,
	input  wire        bit_clock,
	input  wire        frame_clock,
	input  wire        pllOverrate,
	input  wire        dspPostData,
	input  wire        dspPreData,
	output reg         serial_data_out_q,
	output wire [3:0]  bitclk_ratio_setting,
	output wire [3:0]  sample_rate_select,
	output wire        bitClockInvert,
	output reg  [4:0]  clock_detect_status_q,
	output reg         clockError_q
);
	reg  [1:0]  rstPipe_q;
	wire        rstSync_n = rstPipe_q[1];
	reg  [7:0]  pageInc_q;
	reg  [7:0]  ratioRate_q;
	reg  [7:0]  detIgnore_q;
	reg  [7:0]  soutSrc_q;
	reg  [7:0]  portPol_q;
	reg  [1:0]  bclkSync_q;
	reg  [1:0]  fclkSync_q;
	reg  [1:0]  pllSync_q;
	reg  [9:0]  bclkPerFrame_q;
	reg         ratioErr_q;
	reg         rateErr_q;
	wire        bclkRise;
	wire [15:0] bclkPeriod;
	wire        bclkStalled;
	wire        fclkRise;
	wire [15:0] fclkPeriod;
	wire        fclkStalled;
	wire        regSpace = (curBook_q == 8'h00) && (curPage_q == 8'h00);
	wire [7:0]  regAddr = {1'b0, curAddr_q};
	wire        rangeErr;
	wire [4:0]  ignoreVec;
	// the derived stall count is an integer; cut to the meter's width on purpose
	localparam [31:0] MISS_CYC_FULL = `ACC_BCLK_MISS_CYC;
	localparam [15:0] MISS_CYC      = MISS_CYC_FULL[15:0];

	assign bitclk_ratio_setting = ratioRate_q[`ACC_MSB_RATIO:`ACC_LSB_RATIO];
	assign sample_rate_select   = ratioRate_q[`ACC_MSB_RATE:`ACC_LSB_RATE];
	assign bitClockInvert       = portPol_q[`ACC_BIT_CLK_INV];

	// tolerance window around a nominal frame period, compared in nanoseconds
	function inWindow;
		input [15:0] cnt;
		input [15:0] nomNs;
		reg   [31:0] scaled;
		reg   [31:0] nomCyc;
		begin
			scaled   = {16'h0000, cnt} * 32'h00000064 * `ACC_CLK_NS;
			nomCyc   = {16'h0000, nomNs};
			inWindow = (scaled >= nomCyc * (32'h00000064 - `ACC_RATE_TOL_PCT)) &&
				(scaled <= nomCyc * (32'h00000064 + `ACC_RATE_TOL_PCT));
		end
	endfunction

	// reserved codes have no window, so they always read as a rate error
	function rateMatches;
		input [15:0] cnt;
		input [3:0]  mode;
		begin
			case (mode)
				`ACC_RATE_AUTO: rateMatches = inWindow(cnt, `ACC_PER_32K_NS) |
					inWindow(cnt, `ACC_PER_44K1_NS) | inWindow(cnt, `ACC_PER_48K_NS) |
					inWindow(cnt, `ACC_PER_88K2_NS) | inWindow(cnt, `ACC_PER_96K_NS);
				`ACC_RATE_32K:  rateMatches = inWindow(cnt, `ACC_PER_32K_NS);
				`ACC_RATE_44K1: rateMatches = inWindow(cnt, `ACC_PER_44K1_NS);
				`ACC_RATE_48K:  rateMatches = inWindow(cnt, `ACC_PER_48K_NS);
				`ACC_RATE_88K2: rateMatches = inWindow(cnt, `ACC_PER_88K2_NS);
				`ACC_RATE_96K:  rateMatches = inWindow(cnt, `ACC_PER_96K_NS);
				default:        rateMatches = 1'b0;
			endcase
		end
	endfunction

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstPipe_q <= 2'b00;
		else
			rstPipe_q <= {rstPipe_q[0], 1'b1};
	end

	// pin inputs: only the second stage is looked at by logic
	always @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			bclkSync_q <= 2'b00;
			fclkSync_q <= 2'b00;
			pllSync_q  <= 2'b00;
		end
		else if (clkEn)
		begin
			bclkSync_q <= {bclkSync_q[0], bit_clock};
			fclkSync_q <= {fclkSync_q[0], frame_clock};
			pllSync_q  <= {pllSync_q[0], pllOverrate};
		end
	end

	acc_period_meter #(
		.STALL_CYC (MISS_CYC)
	) bclkMeter (
		.core_clk   (core_clk),
		.rstSync_n  (rstSync_n),
		.clkEn      (clkEn),
		.sigIn      (bclkSync_q[1]),
		.riseSeen_q (bclkRise),
		.period_q   (bclkPeriod),
		.stalled_q  (bclkStalled)
	);

	acc_period_meter #(
		.STALL_CYC (`ACC_FRAME_MISS_CYC)
	) fclkMeter (
		.core_clk   (core_clk),
		.rstSync_n  (rstSync_n),
		.clkEn      (clkEn),
		.sigIn      (fclkSync_q[1]),
		.riseSeen_q (fclkRise),
		.period_q   (fclkPeriod),
		.stalled_q  (fclkStalled)
	);

	// a stalled bit clock also lands here as a range error
	assign rangeErr = bclkStalled || (bclkPeriod < `ACC_BCLK_MIN_CYC) ||
		(bclkPeriod > `ACC_BCLK_MAX_CYC);

	// register writes and the pointer stepping share one access strobe
	always @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			pageInc_q    <= `ACC_RST_PAGE_INC;
			ratioRate_q  <= `ACC_RST_RATIO_RATE;
			detIgnore_q  <= `ACC_RST_DET_IGNORE;
			soutSrc_q    <= `ACC_RST_SOUT_SRC;
			portPol_q    <= `ACC_RST_PORT_POL;
			accRdData_q  <= 8'h00;
			accRdValid_q <= 1'b0;
			curBook_q    <= 8'h00;
			curPage_q    <= 8'h00;
			curAddr_q    <= 7'h00;
		end
		else if (clkEn)
		begin
			accRdValid_q <= accStrobe & ~accWrite;
			if (ptrLoad)
			begin
				curBook_q <= ptrBook;
				curPage_q <= ptrPage;
				curAddr_q <= ptrAddr;
			end
			else if (accStrobe)
			begin
				if (accWrite && regSpace)
				begin
					case (regAddr)
						`ACC_OFS_PAGE_INC:   pageInc_q   <= accWrData;
						`ACC_OFS_RATIO_RATE: ratioRate_q <= accWrData;
						`ACC_OFS_DET_IGNORE: detIgnore_q <= accWrData;
						`ACC_OFS_SOUT_SRC:   soutSrc_q   <= {7'h00, accWrData[0]};
						`ACC_OFS_PORT_POL:   portPol_q   <= accWrData;
						default:             ;
					endcase
				end
				if (!accWrite)
				begin
					if (!regSpace)
						accRdData_q <= 8'h00;
					else
					begin
						case (regAddr)
							`ACC_OFS_PAGE_INC:   accRdData_q <= pageInc_q;
							`ACC_OFS_RATIO_RATE: accRdData_q <= ratioRate_q;
							`ACC_OFS_DET_IGNORE: accRdData_q <= detIgnore_q;
							`ACC_OFS_SOUT_SRC:   accRdData_q <= soutSrc_q;
							`ACC_OFS_PORT_POL:   accRdData_q <= portPol_q;
							default:             accRdData_q <= 8'h00;
						endcase
					end
				end
				if (curAddr_q != `ACC_PAGE_LAST)
					curAddr_q <= curAddr_q + 7'h01;
				else if ((curBook_q != 8'h00) && !pageInc_q[`ACC_BIT_WRAP_DIS])
				begin
					curPage_q <= curPage_q + 8'h01;
					curAddr_q <= `ACC_PAGE_RESUME;
				end
				else
					curAddr_q <= 7'h00;
			end
		end
	end

	// ratio and rate are judged once per frame, at the frame clock rise; a stalled frame clock forces both errors
	always @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			bclkPerFrame_q <= 10'h000;
			ratioErr_q     <= 1'b0;
			rateErr_q      <= 1'b0;
		end
		else if (clkEn)
		begin
			if (fclkRise)
			begin
				bclkPerFrame_q <= {9'h000, bclkRise};
				ratioErr_q     <= (bclkPerFrame_q < `ACC_RATIO_MIN) ||
					(bclkPerFrame_q > `ACC_RATIO_MAX);
				rateErr_q      <= ~rateMatches(fclkPeriod, sample_rate_select);
			end
			else
			begin
				if (bclkRise && (bclkPerFrame_q != 10'h3FF))
					bclkPerFrame_q <= bclkPerFrame_q + 10'h001;
				if (fclkStalled)
				begin
					ratioErr_q <= 1'b1;
					rateErr_q  <= 1'b1;
				end
			end
		end
	end

	assign ignoreVec = {detIgnore_q[`ACC_BIT_IGN_PLL], detIgnore_q[`ACC_BIT_IGN_RANGE],
		detIgnore_q[`ACC_BIT_IGN_RATE], detIgnore_q[`ACC_BIT_IGN_RATIO],
		detIgnore_q[`ACC_BIT_IGN_MISS]};

	// status reports every detector; the ignore bits only mask the combined error
	always @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			clock_detect_status_q <= 5'h00;
			clockError_q          <= 1'b0;
			serial_data_out_q     <= 1'b0;
		end
		else if (clkEn)
		begin
			clock_detect_status_q <= {pllSync_q[1], rangeErr, rateErr_q, ratioErr_q,
				bclkStalled};
			clockError_q <= |(clock_detect_status_q & ~ignoreVec);
			serial_data_out_q <= soutSrc_q[`ACC_BIT_SOUT_SEL] ? dspPreData : dspPostData;
		end
	end
endmodule // acc_clock_regs
`default_nettype wire

//--- acc_clock_regs_assertions.sv
// concurrent checks on the ports of the clock configuration bank
`timescale 1ns/10ps
`default_nettype none
module acc_clock_regs_assertions (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       clkEn,
	input wire logic       ptrLoad,
	input wire logic       accStrobe,
	input wire logic       accWrite,
	input wire logic [7:0] accWrData,
	input wire logic       accRdValid_q,
	input wire logic [7:0] curBook_q,
	input wire logic [7:0] curPage_q,
	input wire logic [6:0] curAddr_q,
	input wire logic       pllOverrate,
	input wire logic       dspPostData,
	input wire logic       dspPreData,
	input wire logic       serial_data_out_q,
	input wire logic [3:0] bitclk_ratio_setting,
	input wire logic [3:0] sample_rate_select,
	input wire logic [4:0] clock_detect_status_q,
	input wire logic       clockError_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic accTake = clkEn && accStrobe && !ptrLoad;
	a_read_answer: assert property (accTake && !accWrite |=> accRdValid_q)
		else $error("read not answered");
	a_valid_cause: assert property (accRdValid_q |-> $past(accTake && !accWrite))
		else $error("read valid without read");
	a_addr_step: assert property (accTake && curAddr_q != 7'h7F |=>
		curAddr_q == $past(curAddr_q) + 7'h01) else $error("pointer step wrong");
	a_page_wrap: assert property (accTake && curAddr_q == 7'h7F |=>
		(curAddr_q == 7'h00 && $stable(curPage_q)) || (curBook_q != 8'h00
		&& curAddr_q == 7'h08 && curPage_q == $past(curPage_q) + 8'h01))
		else $error("page end handled wrong");
	a_field_write: assert property (accTake && accWrite && curBook_q == 8'h00
		&& curPage_q == 8'h00 && curAddr_q == 7'h28 |=>
		{bitclk_ratio_setting, sample_rate_select} == $past(accWrData))
		else $error("ratio or rate field not taken");
	a_sout_source: assert property (clkEn && $past(rst_n, 3) |=>
		serial_data_out_q == $past(dspPostData) || serial_data_out_q == $past(dspPreData))
		else $error("serial output from no source");
	a_error_cause: assert property (
		clockError_q |-> $past(clock_detect_status_q) != 5'h00)
		else $error("clock error without detector");
	a_pll_flag: assert property (
		(clkEn && pllOverrate)[*4] |-> clock_detect_status_q[4])
		else $error("pll overrate not flagged");
	a_pll_clear: assert property (
		(clkEn && !pllOverrate)[*4] |-> !clock_detect_status_q[4])
		else $error("pll overrate flag stuck");
endmodule // acc_clock_regs_assertions
bind acc_clock_regs acc_clock_regs_assertions chk (.core_clk, .rst_n, .clkEn, .ptrLoad,
	.accStrobe, .accWrite, .accWrData, .accRdValid_q, .curBook_q, .curPage_q, .curAddr_q,
	.pllOverrate, .dspPostData, .dspPreData, .serial_data_out_q, .bitclk_ratio_setting,
	.sample_rate_select, .clock_detect_status_q, .clockError_q);
`default_nettype wire

//--- acc_defs.vh
// register map, field positions, reset values and timing counts of the clock configuration bank
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

`define ACC_OFS_PAGE_INC      8'h0F
`define ACC_OFS_RATIO_RATE    8'h28
`define ACC_OFS_DET_IGNORE    8'h29
`define ACC_OFS_SOUT_SRC      8'h30
`define ACC_OFS_PORT_POL      8'h31

`define ACC_RST_PAGE_INC      8'h00
`define ACC_RST_RATIO_RATE    8'h00
`define ACC_RST_DET_IGNORE    8'h00
`define ACC_RST_SOUT_SRC      8'h00
`define ACC_RST_PORT_POL      8'h00

`define ACC_BIT_WRAP_DIS      3
`define ACC_MSB_RATIO         7
`define ACC_LSB_RATIO         4
`define ACC_MSB_RATE          3
`define ACC_LSB_RATE          0
`define ACC_BIT_IGN_PLL       6
`define ACC_BIT_IGN_RANGE     5
`define ACC_BIT_IGN_RATE      4
`define ACC_BIT_IGN_RATIO     3
`define ACC_BIT_IGN_MISS      2
`define ACC_BIT_SOUT_SEL      0
`define ACC_BIT_CLK_INV       5

`define ACC_RATIO_32          4'h3
`define ACC_RATIO_64          4'h5
`define ACC_RATIO_128         4'h7
`define ACC_RATIO_256         4'h9
`define ACC_RATIO_512         4'hB

`define ACC_RATE_AUTO         4'h0
`define ACC_RATE_32K          4'h6
`define ACC_RATE_44K1         4'h8
`define ACC_RATE_48K          4'h9
`define ACC_RATE_88K2         4'hA
`define ACC_RATE_96K          4'hB

`define ACC_PAGE_LAST         7'h7F
`define ACC_PAGE_RESUME       7'h08

`define ACC_CLK_NS            10
`define ACC_BCLK_MIN_PER_NS   20
`define ACC_BCLK_MAX_PER_NS   3906
`define ACC_BCLK_MISS_NS      10000
`define ACC_BCLK_MIN_CYC      ((`ACC_BCLK_MIN_PER_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_BCLK_MAX_CYC      (`ACC_BCLK_MAX_PER_NS / `ACC_CLK_NS)
`define ACC_BCLK_MISS_CYC     (`ACC_BCLK_MISS_NS / `ACC_CLK_NS)
`define ACC_FRAME_MISS_CYC    16'hFFFF

`define ACC_RATIO_MIN         10'h020
`define ACC_RATIO_MAX         10'h200

`define ACC_PER_32K_NS        16'h7A12
`define ACC_PER_44K1_NS       16'h5894
`define ACC_PER_48K_NS        16'h5161
`define ACC_PER_88K2_NS       16'h2C4A
`define ACC_PER_96K_NS        16'h28B1
`define ACC_RATE_TOL_PCT      2

`endif

//--- acc_host_model.sv
// host controller model driving the register port
`timescale 1ns/10ps
`default_nettype none
module acc_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] accRdData_q,
	output logic            ptrLoad,
	output logic [7:0]      ptrBook,
	output logic [7:0]      ptrPage,
	output logic [6:0]      ptrAddr,
	output logic            accStrobe,
	output logic            accWrite,
	output logic [7:0]      accWrData
);
	initial
	begin
		{ptrLoad, accStrobe, accWrite} = 3'h0;
		{ptrBook, ptrPage, ptrAddr, accWrData} = 31'h0;
	end
	task automatic point(input logic [7:0] b, input logic [7:0] p, input logic [6:0] a);
	begin
		@(posedge core_clk) #1;
		{ptrLoad, ptrBook, ptrPage, ptrAddr} = {1'b1, b, p, a};
		@(posedge core_clk) #1;
		ptrLoad = 1'b0;
		ptrAddr = ~a;
	end
	endtask
	// released lines show the inverse so a stale value cannot pass
	task automatic access(input logic w, input logic [7:0] d, output logic [7:0] q);
	begin
		@(posedge core_clk) #1;
		{accStrobe, accWrite, accWrData} = {1'b1, w, d};
		@(posedge core_clk) #1;
		accStrobe = 1'b0;
		accWrData = ~d;
		q = accRdData_q;
	end
	endtask
endmodule // acc_host_model
`default_nettype wire

//--- acc_period_meter.v
// measures the period of a synchronised clock in core cycles and flags a stalled clock
`timescale 1ns/10ps
`default_nettype none
module acc_period_meter #(
	parameter [15:0] STALL_CYC = 16'h03E8
) (
	input  wire        core_clk,
	input  wire        rstSync_n,
	input  wire        clkEn,
	input  wire        sigIn,
	output reg         riseSeen_q,
	output reg  [15:0] period_q,
	output reg         stalled_q
);
	reg        sigLast_q;
	reg [15:0] count_q;
	wire       rise = sigIn & ~sigLast_q;

	always @(posedge core_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			sigLast_q  <= 1'b0;
			count_q    <= 16'h0000;
			period_q   <= 16'h0000;
			riseSeen_q <= 1'b0;
			stalled_q  <= 1'b1;
		end
		else if (clkEn)
		begin
			sigLast_q  <= sigIn;
			riseSeen_q <= rise;
			if (rise)
			begin
				period_q  <= count_q + 16'h0001;
				count_q   <= 16'h0000;
				stalled_q <= 1'b0;
			end
			else
			begin
				// saturate so a dead clock never wraps back into range
				if (count_q != 16'hFFFF)
					count_q <= count_q + 16'h0001;
				if (count_q >= STALL_CYC)
					stalled_q <= 1'b1;
			end
		end
	end
endmodule // acc_period_meter
`default_nettype wire

//--- tb.sv
// self-checking bench for the clock configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic       core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, bckRun = 1'b0;
	logic       bit_clock = 1'b0, frame_clock = 1'b0, pllOverrate = 1'b0;
	logic       dspPostData = 1'b0, dspPreData = 1'b0, serial_data_out_q, accRdValid_q;
	logic       bitClockInvert, clockError_q, expBit;
	logic [7:0] accRdData_q, curBook_q, curPage_q, q, d;
	logic [6:0] curAddr_q;
	logic [3:0] bitclk_ratio_setting, sample_rate_select;
	logic [4:0] clock_detect_status_q;
	wire logic  ptrLoad, accStrobe, accWrite;
	wire logic [7:0] ptrBook, ptrPage, accWrData;
	wire logic [6:0] ptrAddr;
	int         failures = 0, checks_done = 0, cycles = 0, bckCnt = 0, seed = 9157;
	logic [6:0] offs [5] = '{7'h0F, 7'h28, 7'h29, 7'h30, 7'h31};
	logic [3:0] ratios [5] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hB};
	logic [3:0] rates [6] = '{4'h0, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
	acc_clock_regs uut (.core_clk, .rst_n, .clkEn, .ptrLoad, .ptrBook, .ptrPage, .ptrAddr,
		.accStrobe, .accWrite, .accWrData, .accRdData_q, .accRdValid_q, .curBook_q,
		.curPage_q, .curAddr_q, .bit_clock, .frame_clock, .pllOverrate, .dspPostData,
		.dspPreData, .serial_data_out_q, .bitclk_ratio_setting, .sample_rate_select,
		.bitClockInvert, .clock_detect_status_q, .clockError_q);
	acc_host_model host (.core_clk, .accRdData_q, .ptrLoad, .ptrBook, .ptrPage, .ptrAddr,
		.accStrobe, .accWrite, .accWrData);
	always #5 core_clk = ~core_clk;
	// bit clock of 325 ns, 64 per frame: close to a 48 kHz frame
	always #162.5 if (bckRun) bit_clock = ~bit_clock;
	always @(posedge bit_clock)
	begin
		bckCnt = (bckCnt + 1) % 32;
		if (bckCnt == 0) frame_clock = ~frame_clock;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			final_report;
		end
	end
	function automatic logic expErr(input logic [4:0] st, input logic [7:0] ign);
		return |(st & ~ign[6:2]);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
	begin
		host.point(8'h00, 8'h00, a);
		host.access(1'b1, v, q);
	end
	endtask
	task automatic rd(input logic [6:0] a);
	begin
		host.point(8'h00, 8'h00, a);
		host.access(1'b0, 8'h00, q);
	end
	endtask
	task automatic wrap(input logic [7:0] b, input logic [7:0] pg, input logic [7:0] ea);
	begin
		host.point(b, 8'h03, 7'h7F);
		host.access(1'b0, 8'h00, q);
		chk(curBook_q, b);
		chk(curPage_q, pg);
		chk(8'(curAddr_q), ea);
	end
	endtask
	task automatic det(input logic [7:0] ign, input logic [4:0] st);
	begin
		wr(7'h29, ign);
		repeat (4) @(posedge core_clk);
		#1;
		chk(8'(clock_detect_status_q), 8'(st));
		chk(8'(clockError_q), 8'(expErr(st, ign)));
	end
	endtask
	task automatic final_report;
	begin
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		foreach (offs[i])
		begin
			rd(offs[i]);
			chk(q, 8'h00);
		end
		$display("test reset values done");
		foreach (rates[i])
		begin
			d = {ratios[i % 5], rates[i]};
			wr(7'h28, d);
			chk({bitclk_ratio_setting, sample_rate_select}, d);
		end
		foreach (offs[i])
		begin
			d = (offs[i] == 7'h28) ? 8'h59 : 8'($random(seed));
			wr(offs[i], d);
			rd(offs[i]);
			chk(q, (offs[i] == 7'h30) ? (d & 8'h01) : d);
		end
		chk(8'(bitClockInvert), 8'(d[5]));
		wr(7'h10, 8'hA5);
		rd(7'h10);
		chk(q, 8'h00);
		// a frozen block must ignore both the pointer load and the write
		@(posedge core_clk) #1;
		clkEn = 1'b0;
		wr(7'h31, ~d);
		clkEn = 1'b1;
		rd(7'h31);
		chk(q, d);
		$display("test register access done");
		wr(7'h0F, 8'h00);
		wrap(8'h01, 8'h04, 8'h08);
		wr(7'h0F, 8'h08);
		wrap(8'h01, 8'h03, 8'h00);
		wrap(8'h00, 8'h03, 8'h00);
		$display("test page wrap done");
		for (int s = 0; s < 2; s++)
		begin
			wr(7'h30, 8'(s));
			repeat (8)
			begin
				@(posedge core_clk) #1;
				{dspPostData, dspPreData} = 2'($random(seed));
				expBit = s ? dspPreData : dspPostData;
				@(posedge core_clk) #1;
				chk(8'(serial_data_out_q), 8'(expBit));
			end
		end
		$display("test serial source done");
		wr(7'h29, 8'h00);
		bckRun = 1'b1;
		repeat (8000) @(posedge core_clk);
		det(8'h00, 5'h00);
		wr(7'h28, 8'h56);
		repeat (5000) @(posedge core_clk);
		det(8'h00, 5'h04);
		det(8'h10, 5'h04);
		wr(7'h28, 8'h59);
		repeat (5000) @(posedge core_clk);
		#1 pllOverrate = 1'b1;
		det(8'h00, 5'h10);
		det(8'h40, 5'h10);
		#1 pllOverrate = 1'b0;
		bckRun = 1'b0;
		repeat (1100) @(posedge core_clk);
		det(8'h00, 5'h09);
		det(8'h24, 5'h09);
		$display("test clock detectors done");
		final_report;
	end
endmodule // tb
`default_nettype wire
